/* rtl/dual_clock_fifo_9bit_flags.sv */
// Overview of operation
// R1: Store word when primary low, secondary high.
// R2: Back-to-back writes on every push edge.
// R3: Input and output words are nine bits.
// R4: Depth is 1K or 2K by parameter.
// R5: Pop moves next word when enabled, non-empty.
// R6: Push and pop clocks tied or independent.
// R7: Writes ignored while full flag is low.
// R8: Secondary pin sampled in reset selects mode.
// R9: Flag mode: primary only write enable.
// R10: Load with primary writes current offset register.
// R11: Load with read enables reads offset register.
// R12: Empty flag exact, updated on pop edges.
// R13: Full flag exact, updated on push edges.
// R14: Near flags compare against programmed offsets.
// R15: Offsets settable in single word steps.
// R16: Offsets default to seven after reset.
// R17: Flags hold at least one clock cycle.
// R18: FIFO reset empties; partner resets before use.
// R19: Output enable low drives data outputs.
// R20: Partner splits write enables for expansion.
// R21: Four eight-bit offset registers.
// R22: Offset accesses cycle four registers, position kept.
// R23: Near empty low at n or fewer words.
// R24: Near full low at depth minus m.
// R25: Pointers cross as Gray code, two stages.
// R26: Partner avoids mixed offset access, reset access.
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_9bit_flags
    import fifo_pkg::*;
#(
    parameter int DEPTH_LOG2 = DEPTH_LOG2_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic fifo_reset_n,
    input wire logic push_clock,
    input wire logic pop_clock,
    input wire logic write_enable_primary,
    input wire logic write_enable_secondary_or_load,
    input wire logic read_enable_a,
    input wire logic read_enable_b,
    input wire logic output_drive_enable_n,
    input wire logic [WORD_W-1:0] write_word_in,
    output logic [WORD_W-1:0] read_word_out,
    output logic read_word_oe_n,
    output logic empty_flag_n,
    output logic near_empty_flag_n,
    output logic full_flag_n,
    output logic near_full_flag_n
);

    // ************************************************************
    // Derived constants and helpers
    // ************************************************************
    // R4: depth build option
    localparam logic [PTR_W-1:0] DEPTH_V = PTR_W'(1 << DEPTH_LOG2);
    localparam logic [PTR_W-1:0] PMASK = PTR_W'((1 << (DEPTH_LOG2 + 1)) - 1);
    localparam logic [PTR_W-1:0] AMASK = PTR_W'((1 << DEPTH_LOG2) - 1);
    localparam logic [BYTE_W-1:0] HI_MASK = BYTE_W'(AMASK >> BYTE_W);

    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p + 12'h001) & PMASK;
    endfunction

    function automatic logic [PTR_W-1:0] fill(input logic [PTR_W-1:0] w,
                                              input logic [PTR_W-1:0] r);
        return (w - r) & PMASK;
    endfunction

    // R15: offsets formed to single word granularity
    function automatic logic [PTR_W-1:0] offset_val(input logic [BYTE_W-1:0] hi,
                                                    input logic [BYTE_W-1:0] lo);
        return PTR_W'({hi, lo}) & AMASK;
    endfunction

    function automatic offset_sel_e sel_next(input offset_sel_e s);
        offset_sel_e n;
        case (s)
            SEL_EMPTY_LO: n = SEL_EMPTY_HI;
            SEL_EMPTY_HI: n = SEL_FULL_LO;
            SEL_FULL_LO: n = SEL_FULL_HI;
            SEL_FULL_HI: n = SEL_EMPTY_LO;
            default: n = SEL_EMPTY_LO;
        endcase
        return n;
    endfunction

    // ************************************************************
    // State and storage
    // ************************************************************
    fifo_state_s st_r;
    fifo_state_s st_nxt;
    logic [WORD_W-1:0] mem [1 << DEPTH_LOG2];
    logic [WORD_W-1:0] mem_rd;
    logic push_edge;
    logic pop_edge;
    logic fifo_write;
    logic fifo_read;
    logic off_write;
    logic off_read;
    logic [PTR_W-1:0] n_off;
    logic [PTR_W-1:0] m_off;
    logic [PTR_W-1:0] wcnt;
    logic [PTR_W-1:0] rcnt;
    logic [BYTE_W-1:0] off_cur;

    // R6: both clocks are sampled levels; each rising edge is an enable pulse
    assign push_edge = push_clock & ~st_r.push_prev & fifo_reset_n;
    assign pop_edge = pop_clock & ~st_r.pop_prev & fifo_reset_n;
    // R14: offsets feed near flags
    assign n_off = offset_val(st_r.off[SEL_EMPTY_HI], st_r.off[SEL_EMPTY_LO]);
    assign m_off = offset_val(st_r.off[SEL_FULL_HI], st_r.off[SEL_FULL_LO]);
    assign off_cur = st_r.off[st_r.sel];

    // R1: in either mode a buffer write needs primary low and the other pin high
    // R7: the registered full flag blocks the write
    // R9: in flag mode the pin high means load is not selected
    assign fifo_write = push_edge & ~write_enable_primary & write_enable_secondary_or_load
                        & st_r.full_n;
    // R10: load write targets the offset register
    assign off_write = push_edge & ~st_r.two_we & ~write_enable_primary
                       & ~write_enable_secondary_or_load;
    // R11: load read presents the offset register
    assign off_read = pop_edge & ~st_r.two_we & ~write_enable_secondary_or_load
                      & ~read_enable_a & ~read_enable_b;
    // R5: underflow protection uses the registered empty flag
    assign fifo_read = pop_edge & ~read_enable_a & ~read_enable_b & st_r.empty_n
                       & ~off_read;

    assign mem_rd = mem[st_r.rbin[DEPTH_LOG2-1:0]];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        wcnt = fill(st_r.wbin, from_gray(st_r.rg_s2));
        rcnt = fill(from_gray(st_r.wg_s2), st_r.rbin);
        st_nxt.push_prev = push_clock;
        st_nxt.pop_prev = pop_clock;
        // R19: output enable follows its pin
        st_nxt.oe_n = output_drive_enable_n;
        if (!fifo_reset_n) begin
            // R8: the dual-purpose pin is caught while reset is held
            st_nxt.two_we = write_enable_secondary_or_load;
            // R18: back to the empty condition
            st_nxt.wbin = PTR_RESET;
            st_nxt.wgray = PTR_RESET;
            st_nxt.rbin = PTR_RESET;
            st_nxt.rgray = PTR_RESET;
            st_nxt.rg_s1 = PTR_RESET;
            st_nxt.rg_s2 = PTR_RESET;
            st_nxt.wg_s1 = PTR_RESET;
            st_nxt.wg_s2 = PTR_RESET;
            // R16: defaults of seven
            st_nxt.off[SEL_EMPTY_LO] = OFFSET_LO_DEFAULT;
            st_nxt.off[SEL_EMPTY_HI] = OFFSET_HI_DEFAULT;
            st_nxt.off[SEL_FULL_LO] = OFFSET_LO_DEFAULT;
            st_nxt.off[SEL_FULL_HI] = OFFSET_HI_DEFAULT;
            st_nxt.sel = SEL_EMPTY_LO;
            st_nxt.empty_n = 1'b0;
            st_nxt.near_empty_n = 1'b0;
            st_nxt.full_n = 1'b1;
            st_nxt.near_full_n = 1'b1;
            st_nxt.dout = WORD_RESET;
        end else begin
            if (push_edge) begin
                // R25: read pointer enters the push side through two stages
                st_nxt.rg_s1 = st_r.rgray;
                st_nxt.rg_s2 = st_r.rg_s1;
                // R2: a write on every qualifying edge
                if (fifo_write) begin
                    st_nxt.wbin = ptr_inc(st_r.wbin);
                    st_nxt.wgray = to_gray(st_nxt.wbin);
                end
                // R21: high bytes keep only bits that the depth uses
                // R22: the selector steps and wraps
                if (off_write) begin
                    if (st_r.sel == SEL_EMPTY_HI || st_r.sel == SEL_FULL_HI) begin
                        st_nxt.off[st_r.sel] = write_word_in[BYTE_W-1:0] & HI_MASK;
                    end else begin
                        st_nxt.off[st_r.sel] = write_word_in[BYTE_W-1:0];
                    end
                    st_nxt.sel = sel_next(st_r.sel);
                end
                // The flag takes the first stage because the second stage loads it at this edge.
                // Every stage runs on clk, so the pointer seen here is never metastable.
                wcnt = fill(st_nxt.wbin, from_gray(st_r.rg_s1));
                // R13: full flag moves only here
                st_nxt.full_n = (wcnt != DEPTH_V);
                // R24: near full at depth minus m
                st_nxt.near_full_n = (wcnt < (DEPTH_V - m_off));
            end
            if (pop_edge) begin
                // R25: write pointer enters the pop side through two stages
                st_nxt.wg_s1 = st_r.wgray;
                st_nxt.wg_s2 = st_r.wg_s1;
                if (fifo_read) begin
                    st_nxt.dout = mem_rd;
                    st_nxt.rbin = ptr_inc(st_r.rbin);
                    st_nxt.rgray = to_gray(st_nxt.rbin);
                end else if (off_read) begin
                    st_nxt.dout = {1'b0, st_r.off[st_nxt.sel]};
                    st_nxt.sel = sel_next(st_nxt.sel);
                end
                rcnt = fill(from_gray(st_r.wg_s1), st_nxt.rbin);
                // R12: empty flag moves only here
                st_nxt.empty_n = (rcnt != PTR_RESET);
                // R23: near empty at n or fewer
                st_nxt.near_empty_n = (rcnt > n_off);
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // R17: flags change only on their own edge, so each holds a full cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{
                push_prev: 1'b0, pop_prev: 1'b0, two_we: 1'b1,
                wbin: PTR_RESET, wgray: PTR_RESET, rbin: PTR_RESET, rgray: PTR_RESET,
                rg_s1: PTR_RESET, rg_s2: PTR_RESET, wg_s1: PTR_RESET, wg_s2: PTR_RESET,
                off: {OFFSET_HI_DEFAULT, OFFSET_LO_DEFAULT, OFFSET_HI_DEFAULT,
                      OFFSET_LO_DEFAULT},
                sel: SEL_EMPTY_LO, empty_n: 1'b0, near_empty_n: 1'b0, full_n: 1'b1,
                near_full_n: 1'b1, dout: WORD_RESET, oe_n: 1'b1
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // The array has no reset; the pointers alone define what is valid.
    always_ff @(posedge clk) begin
        if (fifo_write) begin
            mem[st_r.wbin[DEPTH_LOG2-1:0]] <= write_word_in;
        end
    end

    // R3: nine-bit output word
    assign read_word_out = st_r.dout;
    assign read_word_oe_n = st_r.oe_n;
    assign empty_flag_n = st_r.empty_n;
    assign near_empty_flag_n = st_r.near_empty_n;
    assign full_flag_n = st_r.full_n;
    assign near_full_flag_n = st_r.near_full_n;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_offset_access;
        fifo_reset_n && (off_write ^ off_read);
    endsequence

    sequence s_sel_stepped;
        fifo_reset_n && st_r.sel == sel_next($past(st_r.sel));
    endsequence

    sequence s_pop_qualified;
        fifo_reset_n && pop_edge && !read_enable_a && !read_enable_b && st_r.empty_n
        && !off_read;
    endsequence

    sequence s_offset_read;
        fifo_reset_n && off_read && !off_write;
    endsequence

    a_full_blocks_write: assert property ( // R7
        (fifo_reset_n && push_edge && !st_r.full_n) |=> st_r.wbin == $past(st_r.wbin))
        else $error("write pointer moved while full");

    a_write_advances: assert property ( // R1
        (fifo_reset_n && push_edge && !write_enable_primary && write_enable_secondary_or_load
         && st_r.full_n) |=> st_r.wbin == ptr_inc($past(st_r.wbin)))
        else $error("qualified write did not advance pointer");

    a_pop_moves_word: assert property ( // R5
        s_pop_qualified |=> read_word_out == $past(mem_rd))
        else $error("pop did not present the next word");

    a_empty_exact: assert property ( // R12
        fifo_reset_n |-> (!empty_flag_n == (fill(from_gray(st_r.wg_s2), st_r.rbin) == 12'h000)))
        else $error("empty flag disagrees with fill level");

    a_empty_pop_only: assert property ( // R12
        (fifo_reset_n && $past(fifo_reset_n) && $changed(empty_flag_n)) |-> $past(pop_edge))
        else $error("empty flag moved without a pop edge");

    a_full_push_only: assert property ( // R13
        (fifo_reset_n && $past(fifo_reset_n) && ($changed(full_flag_n) ||
         $changed(near_full_flag_n))) |-> $past(push_edge))
        else $error("full flags moved without a push edge");

    a_near_empty_level: assert property ( // R23
        (fifo_reset_n && pop_edge) |=>
        near_empty_flag_n == (fill(from_gray(st_r.wg_s2), st_r.rbin) > $past(n_off)))
        else $error("near empty flag wrong after pop edge");

    a_near_full_level: assert property ( // R24
        (fifo_reset_n && push_edge) |=>
        near_full_flag_n == (fill(st_r.wbin, from_gray(st_r.rg_s2)) < (DEPTH_V - $past(m_off))))
        else $error("near full flag wrong after push edge");

    a_offset_stepping: assert property ( // R22
        s_offset_access |=> s_sel_stepped)
        else $error("offset selector did not step");

    a_reset_defaults: assert property ( // R16
        !fifo_reset_n |=> (!empty_flag_n && full_flag_n && n_off == 12'h007
                           && m_off == 12'h007 && st_r.two_we == $past(write_enable_secondary_or_load)))
        else $error("fifo reset did not restore defaults");

    a_oe_follows: assert property ( // R19
        ##1 read_word_oe_n == $past(output_drive_enable_n))
        else $error("output enable did not follow its pin");

    a_full_exact: assert property ( // R13
        fifo_reset_n |-> (!full_flag_n == (fill(st_r.wbin, from_gray(st_r.rg_s2)) == DEPTH_V)))
        else $error("full flag disagrees with fill level");

    a_near_empty_pop_only: assert property ( // R12
        (fifo_reset_n && $past(fifo_reset_n) && $changed(near_empty_flag_n))
        |-> $past(pop_edge))
        else $error("near empty flag moved without a pop edge");

    a_read_refused_empty: assert property ( // R5
        (fifo_reset_n && pop_edge && !st_r.empty_n && !off_read) |=>
        (read_word_out == $past(read_word_out) && st_r.rbin == $past(st_r.rbin)))
        else $error("read taken from an empty buffer");

    a_offset_load_write: assert property ( // R10
        (fifo_reset_n && off_write && st_r.sel == SEL_EMPTY_LO) |=>
        (st_r.off[SEL_EMPTY_LO] == $past(write_word_in[BYTE_W-1:0])
         && st_r.wbin == $past(st_r.wbin)))
        else $error("load write missed the offset register");

    a_offset_read_out: assert property ( // R11
        s_offset_read |=> read_word_out == {1'b0, $past(off_cur)})
        else $error("load read did not present the offset");

    a_empty_flags_hold: assert property ( // R17
        (fifo_reset_n && $past(fifo_reset_n) && ($changed(empty_flag_n) ||
         $changed(near_empty_flag_n))) |=>
        ($stable(empty_flag_n) && $stable(near_empty_flag_n)))
        else $error("empty flags did not hold a cycle");

    a_full_flags_hold: assert property ( // R17
        (fifo_reset_n && $past(fifo_reset_n) && ($changed(full_flag_n) ||
         $changed(near_full_flag_n))) |=>
        ($stable(full_flag_n) && $stable(near_full_flag_n)))
        else $error("full flags did not hold a cycle");

    a_mode_holds: assert property ( // R8
        fifo_reset_n |=> st_r.two_we == $past(st_r.two_we))
        else $error("mode changed outside fifo reset");

endmodule

`default_nettype wire

/* rtl/fifo_pkg.sv */
package fifo_pkg;

    // ************************************************************
    // Widths and layout
    // ************************************************************
    localparam int WORD_W = 9;
    localparam int PTR_W = 12;
    localparam int BYTE_W = 8;
    localparam int NUM_OFFSETS = 4;
    localparam int DEPTH_LOG2_DEFAULT = 10;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [BYTE_W-1:0] OFFSET_LO_DEFAULT = 8'h07;
    localparam logic [BYTE_W-1:0] OFFSET_HI_DEFAULT = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 9'h000;
    localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SEL_EMPTY_LO = 2'b00,
        SEL_EMPTY_HI = 2'b01,
        SEL_FULL_LO = 2'b10,
        SEL_FULL_HI = 2'b11
    } offset_sel_e;

    typedef struct packed {
        logic push_prev;
        logic pop_prev;
        logic two_we;
        logic [PTR_W-1:0] wbin;
        logic [PTR_W-1:0] wgray;
        logic [PTR_W-1:0] rbin;
        logic [PTR_W-1:0] rgray;
        logic [PTR_W-1:0] rg_s1;
        logic [PTR_W-1:0] rg_s2;
        logic [PTR_W-1:0] wg_s1;
        logic [PTR_W-1:0] wg_s2;
        logic [NUM_OFFSETS-1:0][BYTE_W-1:0] off;
        offset_sel_e sel;
        logic empty_n;
        logic near_empty_n;
        logic full_n;
        logic near_full_n;
        logic [WORD_W-1:0] dout;
        logic oe_n;
    } fifo_state_s;

    typedef struct packed {
        logic empty_n;
        logic near_empty_n;
        logic full_n;
        logic near_full_n;
    } fifo_flags_s;

endpackage

/* test/fifo_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module fifo_far_side
    import fifo_pkg::*;
(
    input wire logic clk,
    output logic push_clock,
    output logic pop_clock,
    output logic write_enable_primary,
    output logic write_enable_secondary_or_load,
    output logic read_enable_a,
    output logic read_enable_b,
    output logic [WORD_W-1:0] write_word_in
);
    initial begin
        push_clock = 1'b0;
        pop_clock = 1'b0;
        write_enable_primary = 1'b1;
        write_enable_secondary_or_load = 1'b1;
        read_enable_a = 1'b1;
        read_enable_b = 1'b1;
        write_word_in = 9'h000;
    end
    // mode pin moves on request here, and push also drives it.
    task automatic set_we2(input logic v);
        @(posedge clk);
        write_enable_secondary_or_load <= v;
    endtask
    // Clocks stand low between words, and released data swings so a stale value cannot pass.
    task automatic push(input logic [WORD_W-1:0] d, input logic we1, input logic we2);
        @(posedge clk);
        push_clock <= 1'b1;
        write_enable_primary <= we1;
        write_enable_secondary_or_load <= we2;
        write_word_in <= d;
        @(posedge clk);
        push_clock <= 1'b0;
        write_enable_primary <= 1'b1;
        write_word_in <= ~d;
    endtask
    task automatic pop(input logic ra, input logic rb);
        @(posedge clk);
        pop_clock <= 1'b1;
        read_enable_a <= ra;
        read_enable_b <= rb;
        @(posedge clk);
        pop_clock <= 1'b0;
        read_enable_a <= 1'b1;
        read_enable_b <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* test/test_dual_clock_fifo_9bit_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dual_clock_fifo_9bit_flags;
    import fifo_pkg::*;
    localparam int DEPTH = 1 << DEPTH_LOG2_DEFAULT;
    logic clk, resetn, fifo_reset_n, output_drive_enable_n;
    logic push_clock, pop_clock, read_enable_a, read_enable_b;
    logic write_enable_primary, write_enable_secondary_or_load;
    logic [WORD_W-1:0] write_word_in, read_word_out;
    logic read_word_oe_n, empty_flag_n, near_empty_flag_n, full_flag_n, near_full_flag_n;
    int n_mismatch, n_tests, cycles;

    fifo_far_side far (.clk(clk), .push_clock(push_clock), .pop_clock(pop_clock),
        .write_enable_primary(write_enable_primary),
        .write_enable_secondary_or_load(write_enable_secondary_or_load),
        .read_enable_a(read_enable_a), .read_enable_b(read_enable_b),
        .write_word_in(write_word_in));

    dual_clock_fifo_9bit_flags #(.DEPTH_LOG2(DEPTH_LOG2_DEFAULT)) DUT (.clk(clk),
        .resetn(resetn), .fifo_reset_n(fifo_reset_n), .push_clock(push_clock),
        .pop_clock(pop_clock), .write_enable_primary(write_enable_primary),
        .write_enable_secondary_or_load(write_enable_secondary_or_load),
        .read_enable_a(read_enable_a), .read_enable_b(read_enable_b),
        .output_drive_enable_n(output_drive_enable_n), .write_word_in(write_word_in),
        .read_word_out(read_word_out), .read_word_oe_n(read_word_oe_n),
        .empty_flag_n(empty_flag_n), .near_empty_flag_n(near_empty_flag_n),
        .full_flag_n(full_flag_n), .near_full_flag_n(near_full_flag_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ************************************************************
    // Checks and helpers
    // ************************************************************
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic report(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [WORD_W-1:0] exp);
        report(read_word_out, exp);
    endtask
    // Flag order is empty, near empty, full, near full.
    task automatic check_flags(input logic [3:0] exp);
        report({5'h00, empty_flag_n, near_empty_flag_n, full_flag_n, near_full_flag_n},
            {5'h00, exp});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pop_check(input logic [WORD_W-1:0] exp);
        far.pop(1'b0, 1'b0);
        settle(2);
        check_word(exp);
    endtask
    task automatic idle(input int n);
        repeat (n) far.pop(1'b1, 1'b1);
        repeat (n) far.push(9'h000, 1'b1, 1'b1);
        settle(1);
    endtask
    task automatic do_reset(input logic two_we);
        @(posedge clk);
        fifo_reset_n <= 1'b0;
        far.set_we2(two_we);
        repeat (3) @(posedge clk);
        fifo_reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_basic();
        do_reset(1'b1);
        settle(1);
        check_flags(4'b0011);
        check_word(9'h000);
        far.push(9'h1a5, 1'b0, 1'b1);
        far.push(9'h05a, 1'b0, 1'b1);
        far.push(9'h100, 1'b0, 1'b1);
        far.push(9'h0ff, 1'b1, 1'b1);
        far.push(9'h0ee, 1'b0, 1'b0);
        idle(4);
        check_flags(4'b1011);
        far.pop(1'b1, 1'b0);
        far.pop(1'b0, 1'b1);
        settle(2);
        check_word(9'h000);
        pop_check(9'h1a5);
        pop_check(9'h05a);
        pop_check(9'h100);
        idle(3);
        check_flags(4'b0011);
        pop_check(9'h100);
    endtask
    task automatic t_near_empty();
        for (int i = 0; i < 8; i++) far.push(9'h010 + i[8:0], 1'b0, 1'b1);
        idle(4);
        check_flags(4'b1111);
        pop_check(9'h010);
        idle(2);
        check_flags(4'b1011);
        for (int i = 1; i < 8; i++) pop_check(9'h010 + i[8:0]);
    endtask
    task automatic t_full();
        for (int i = 0; i < DEPTH - 8; i++) far.push(i[8:0], 1'b0, 1'b1);
        idle(4);
        check_flags(4'b1111);
        far.push(9'((DEPTH - 8) % 512), 1'b0, 1'b1);
        settle(1);
        check_flags(4'b1110);
        for (int i = DEPTH - 7; i < DEPTH; i++) far.push(i[8:0], 1'b0, 1'b1);
        settle(1);
        check_flags(4'b1100);
        far.push(9'h0aa, 1'b0, 1'b1);
        pop_check(9'h000);
        idle(4);
        check_flags(4'b1110);
        for (int i = 1; i < DEPTH; i++) pop_check(i[8:0]);
        idle(4);
        check_flags(4'b0011);
    endtask
    task automatic t_offsets();
        do_reset(1'b0);
        far.push(9'h003, 1'b0, 1'b0);
        far.push(9'h000, 1'b0, 1'b0);
        far.push(9'h005, 1'b0, 1'b0);
        far.push(9'h000, 1'b0, 1'b0);
        pop_check(9'h003);
        pop_check(9'h000);
        pop_check(9'h005);
        pop_check(9'h000);
        pop_check(9'h003);
        for (int i = 0; i < 4; i++) far.push(9'h040 + i[8:0], 1'b0, 1'b1);
        idle(4);
        check_flags(4'b1111);
        pop_check(9'h040);
        fork
            far.push(9'h1c3, 1'b0, 1'b1);
            far.pop(1'b0, 1'b0);
        join
        settle(2);
        check_word(9'h041);
        far.set_we2(1'b0);
        pop_check(9'h000);
        pop_check(9'h005);
        do_reset(1'b1);
        settle(1);
        check_flags(4'b0011);
        check_word(9'h000);
    endtask
    task automatic t_oe();
        @(posedge clk);
        output_drive_enable_n <= 1'b0;
        settle(2);
        report({8'h00, read_word_oe_n}, 9'h000);
        @(posedge clk);
        output_drive_enable_n <= 1'b1;
        settle(2);
        report({8'h00, read_word_oe_n}, 9'h001);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        cycles = 0;
        resetn = 1'b0;
        fifo_reset_n = 1'b0;
        output_drive_enable_n = 1'b1;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_basic();
        t_near_empty();
        t_full();
        t_offsets();
        t_oe();
        finish_test();
    end
endmodule
`default_nettype wire
